//--- verilog/wdc_pkg.sv
// constants for the keyboard-controller watchdog countdown block
// assumes an 8-bit memory-mapped register port and a free-running 32 kHz input
package wdc_pkg;
	// =====================================================
	// register map
	localparam logic [15:0] WDC_ADDR_CTRL = 16'h7f37;
	localparam logic [15:0] WDC_ADDR_COUNT = 16'h7f38;
	localparam int WDC_BIT_UNLOCK = 0;
	localparam int WDC_BIT_RUN = 1;
	localparam logic [7:0] WDC_CTRL_RESET = 8'h00;
	localparam logic [7:0] WDC_COUNT_RESET = 8'hff;
	localparam logic [7:0] WDC_COUNT_OFF = 8'h00;
	localparam logic [7:0] WDC_COUNT_LAST = 8'h01;
	localparam logic [7:0] WDC_READ_NONE = 8'h00;
	// =====================================================
	// prescaler: one countdown step every 512 slow-clock edges
	localparam int WDC_PRESC_W = 9;
	localparam logic [8:0] WDC_PRESC_RESET = 9'h000;
	localparam logic [8:0] WDC_PRESC_LAST = 9'h1ff;
endpackage

//--- verilog/wdc_slow_sync.sv
// slow-clock edge detector for the watchdog prescaler
// assumes slow_clk_i is asynchronous to sys_clk_i and much slower
`timescale 1ns/10ps
`default_nettype none
module wdc_slow_sync (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic slow_clk_i,
	output logic edge_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic edge_reg;
	wire logic rise_next;

	// =====================================================
	// three-stage capture; only stages two and three are compared
	assign rise_next = s2_reg & ~s3_reg;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			edge_reg <= 1'b0;
		end else begin
			s1_reg <= slow_clk_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			edge_reg <= rise_next;
		end
	end

	assign edge_o = edge_reg;
endmodule
`default_nettype wire

//--- verilog/wdc_watchdog.sv
// watchdog countdown: 8-bit down counter behind a 9-bit prescaler
// assumes rst_i is the main power-on reset and that main_power_on_reset_o is wired back to it
//
// How it works
// - eight-bit countdown stepped by a nine-bit prescaler on the 32 kHz clock
// - countdown steps once per 512 slow-clock edges, about 16 ms
// - interval runs 16 ms to 4.08 s in 16 ms steps by loaded count
// - underflow while running raises main power-on reset
// - slow clock keeps running in idle and sleep, so counting goes on
// - inactive after reset; starts when firmware sets run-enable bit D1
// - count writes take effect only while reload-unlock bit D0 is set
// - any count write clears reload-unlock
// - load 01h gives one step, 0FFh gives the longest interval
// - accepted write of 00h clears run-enable and reload-unlock
// - every count load restarts the prescaler from zero
// - run-enable clears only by reset or unlock-then-write-zero
`timescale 1ns/10ps
`default_nettype none
module wdc_watchdog
	import wdc_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic slow_clk_i,
	input wire logic [15:0] mmcr_addr_i,
	input wire logic [7:0] mmcr_wdata_i,
	input wire logic mmcr_wr_i,
	input wire logic mmcr_rd_i,
	output logic [7:0] mmcr_rdata_o,
	output logic dog_run_enable_o,
	output logic main_power_on_reset_o
);
	logic run_reg;
	logic unlock_reg;
	logic [7:0] count_reg;
	logic [WDC_PRESC_W-1:0] presc_reg;
	logic por_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	wire logic slow_edge;

	// =====================================================
	// slow clock edge, runs regardless of controller power state
	wdc_slow_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.slow_clk_i(slow_clk_i),
		.edge_o(slow_edge)
	);

	// =====================================================
	// register decode
	wire logic sel_ctrl = mmcr_addr_i == WDC_ADDR_CTRL;
	wire logic sel_count = mmcr_addr_i == WDC_ADDR_COUNT;
	wire logic wr_ctrl = mmcr_wr_i & sel_ctrl;
	wire logic wr_count = mmcr_wr_i & sel_count;
	wire logic load = wr_count & unlock_reg;
	wire logic load_zero = load & (mmcr_wdata_i == WDC_COUNT_OFF);
	wire logic active = run_reg & ~por_reg;
	wire logic step = active & slow_edge & (presc_reg == WDC_PRESC_LAST);
	wire logic underflow = step & (count_reg <= WDC_COUNT_LAST) & ~load;
	wire logic [7:0] ctrl_view = {6'h00, run_reg, unlock_reg};

	assign rdata_next = ~mmcr_rd_i ? WDC_READ_NONE :
		sel_ctrl ? ctrl_view :
		sel_count ? count_reg : WDC_READ_NONE;

	// =====================================================
	// control bits
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_reg <= 1'b0;
			unlock_reg <= 1'b0;
		end else begin
			if (load_zero) begin
				run_reg <= 1'b0;
			end else if (wr_ctrl & mmcr_wdata_i[WDC_BIT_RUN]) begin
				run_reg <= 1'b1;
			end
			if (wr_count) begin
				unlock_reg <= 1'b0;
			end else if (wr_ctrl) begin
				unlock_reg <= mmcr_wdata_i[WDC_BIT_UNLOCK];
			end
		end
	end

	// =====================================================
	// countdown and prescaler; a load wins over a step in the same cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_reg <= WDC_COUNT_RESET;
			presc_reg <= WDC_PRESC_RESET;
		end else if (load) begin
			count_reg <= mmcr_wdata_i;
			presc_reg <= WDC_PRESC_RESET;
		end else if (active & slow_edge) begin
			presc_reg <= presc_reg + 9'h001;
			if (step & ~underflow) begin
				count_reg <= count_reg - 8'h01;
			end
		end
	end

	// =====================================================
	// reset request stays up until the main reset comes back to us,
	// so a slow reset tree cannot miss it
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			por_reg <= 1'b0;
			rdata_reg <= WDC_READ_NONE;
		end else begin
			if (underflow) begin
				por_reg <= 1'b1;
			end
			rdata_reg <= rdata_next;
		end
	end

	assign mmcr_rdata_o = rdata_reg;
	assign dog_run_enable_o = run_reg;
	assign main_power_on_reset_o = por_reg;

	// =====================================================
	// checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	AST_STEP_DEC: assert property (step && !load && count_reg > 8'h01 |=>
		count_reg == 8'($past(count_reg) - 8'h01))
		else $error("countdown did not step down");
	AST_UNDERFLOW_POR: assert property (active && step && !load && count_reg == 8'h01 |=>
		main_power_on_reset_o ##1 main_power_on_reset_o)
		else $error("underflow did not raise reset");
	AST_HOLD_OFF: assert property (!run_reg && !load |=>
		$stable(count_reg) && $stable(presc_reg) && !$rose(main_power_on_reset_o))
		else $error("disabled watchdog moved");
	AST_LOCKED_WRITE: assert property (wr_count && !unlock_reg && !run_reg |=>
		$stable(count_reg))
		else $error("locked write changed count");
	AST_UNLOCK_SELF_CLEAR: assert property (wr_count |=> !unlock_reg)
		else $error("unlock did not clear on count write");
	AST_ZERO_DISABLES: assert property (load_zero |=> !run_reg && !unlock_reg && count_reg == 8'h00)
		else $error("zero load did not disable");
	AST_PRESC_RESTART: assert property (load |=> presc_reg == 9'h000 && count_reg == $past(mmcr_wdata_i))
		else $error("load did not restart prescaler");
	AST_RUN_STICKY: assert property (run_reg && !load_zero |=> run_reg)
		else $error("run-enable dropped without sequence");
	AST_START_ON_WRITE: assert property (!run_reg && !(wr_ctrl && mmcr_wdata_i[1]) |=> !run_reg)
		else $error("run-enable rose without write");
	AST_READ_CTRL: assert property (mmcr_rd_i && sel_ctrl |=> mmcr_rdata_o[1:0] == $past(ctrl_view[1:0]))
		else $error("control read mismatch");
	AST_CTRL_UPPER_ZERO: assert property (mmcr_rd_i && sel_ctrl |=> mmcr_rdata_o[7:2] == 6'h00)
		else $error("reserved control bits read nonzero");
	AST_RUN_SET: assert property (wr_ctrl && mmcr_wdata_i[WDC_BIT_RUN] && !load_zero |=> run_reg)
		else $error("run-enable write did not set");

	// =====================================================
	// prescaler behaviour; a stuck or free-running prescaler would
	// stretch or shrink every interval without touching the count
	AST_PRESC_STEP: assert property (active && slow_edge && !load |=>
		presc_reg == 9'($past(presc_reg) + 9'h001))
		else $error("prescaler did not advance on slow edge");
	AST_PRESC_HOLD: assert property (!slow_edge && !load |=> $stable(presc_reg))
		else $error("prescaler moved without slow edge");

	// =====================================================
	// once the reset request is up the counter stops stepping, so the
	// request cannot be withdrawn by a later load or step
	AST_POR_STICKY: assert property (main_power_on_reset_o |=> main_power_on_reset_o)
		else $error("reset request dropped before main reset");
	AST_POR_FROZEN: assert property (por_reg && !load |=> $stable(count_reg) && $stable(presc_reg))
		else $error("counter moved after reset request");
	AST_NO_POR_OFF: assert property (!run_reg |=> !$rose(main_power_on_reset_o))
		else $error("reset request raised while disabled");

	COV_UNDERFLOW: cover property (underflow);
	COV_RELOAD: cover property (wr_ctrl && mmcr_wdata_i[0] ##[1:20] load && !load_zero);
	COV_DISABLE: cover property (run_reg ##[1:20] load_zero);
	COV_LOCKED_WRITE: cover property (wr_count && !unlock_reg);
endmodule
`default_nettype wire

//--- verif/wdc_watchdog_tb.sv
// bench for the watchdog countdown: register access, unlock sequence, underflow timing
// assumes the slow clock may run far faster than 32 kHz so a full interval stays short
`timescale 1ns/10ps
`default_nettype none
module wdc_watchdog_tb;
	import wdc_pkg::*;
	// =====================================================
	// stimulus and clocks
	localparam int SP = 8; // sys cycles per slow period, fast on purpose
	logic sys_clk_i = 0, rst_i = 1, slow_clk_i = 0, mmcr_wr_i = 0, mmcr_rd_i = 0;
	logic [15:0] mmcr_addr_i = 16'h0000;
	logic [7:0] mmcr_wdata_i = 8'h00, mmcr_rdata_o, val;
	logic dog_run_enable_o, main_power_on_reset_o;
	int n_errors = 0, total_checks = 0, n, c;
	always #50 sys_clk_i = ~sys_clk_i;
	always #400 slow_clk_i = ~slow_clk_i;
	wdc_watchdog uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_clk_i(slow_clk_i), .mmcr_addr_i(mmcr_addr_i),
		.mmcr_wdata_i(mmcr_wdata_i), .mmcr_wr_i(mmcr_wr_i), .mmcr_rd_i(mmcr_rd_i), .mmcr_rdata_o(mmcr_rdata_o),
		.dog_run_enable_o(dog_run_enable_o), .main_power_on_reset_o(main_power_on_reset_o));
	// =====================================================
	// tasks
	task automatic results();
		if (n_errors == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick();
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		mmcr_wr_i <= 1'b1;
		mmcr_addr_i <= a;
		mmcr_wdata_i <= d;
		tick();
		mmcr_wr_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		mmcr_rd_i <= 1'b1;
		mmcr_addr_i <= a;
		@(posedge sys_clk_i);
		mmcr_rd_i <= 1'b0;
		#1;
		chk("rdata", {8'h00, mmcr_rdata_o}, {8'h00, exp});
	endtask
	task automatic do_rst();
		rst_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		tick();
	endtask
	// expected underflow: count steps of 512 slow edges each, from the load
	function automatic int exp_cyc(input int cnt);
		return cnt * 512 * SP;
	endfunction
	task automatic wait_por(input int cnt);
		for (n = 0; n < exp_cyc(cnt) + 64 && main_power_on_reset_o !== 1'b1; n++) tick();
		chk("por_seen", {15'h0, main_power_on_reset_o}, 16'h0001);
		chk("por_early", {15'h0, n >= exp_cyc(cnt) - 16}, 16'h0001);
		if (main_power_on_reset_o !== 1'b1) results();
	endtask
	// =====================================================
	// main sequence
	initial begin
		n = $urandom(51);
		do_rst();
		chk("run", {15'h0, dog_run_enable_o}, 16'h0000);
		rdchk(WDC_ADDR_CTRL, WDC_CTRL_RESET);
		rdchk(WDC_ADDR_COUNT, WDC_COUNT_RESET);
		rdchk(16'h7f39, WDC_READ_NONE);
		val = 8'($urandom_range(2, 255));
		wr(WDC_ADDR_COUNT, val);
		rdchk(WDC_ADDR_COUNT, WDC_COUNT_RESET);
		wr(WDC_ADDR_CTRL, 8'h02);
		chk("run", {15'h0, dog_run_enable_o}, 16'h0001);
		wr(WDC_ADDR_CTRL, 8'h00);
		rdchk(WDC_ADDR_CTRL, 8'h02);
		wr(WDC_ADDR_CTRL, 8'hff);
		rdchk(WDC_ADDR_CTRL, 8'h03);
		wr(WDC_ADDR_COUNT, val);
		rdchk(WDC_ADDR_COUNT, val);
		rdchk(WDC_ADDR_CTRL, 8'h02);
		wr(WDC_ADDR_COUNT, ~val);
		rdchk(WDC_ADDR_COUNT, val);
		wr(WDC_ADDR_CTRL, 8'h03);
		wr(WDC_ADDR_COUNT, WDC_COUNT_OFF);
		chk("run", {15'h0, dog_run_enable_o}, 16'h0000);
		rdchk(WDC_ADDR_CTRL, 8'h00);
		repeat (600 * SP) tick();
		chk("por_off", {15'h0, main_power_on_reset_o}, 16'h0000);
		rdchk(WDC_ADDR_COUNT, WDC_COUNT_OFF);
		// a mid-interval reload must restart the prescaler, else the second wait ends early
		for (c = 1; c <= 2; c++) begin
			wr(WDC_ADDR_CTRL, 8'h03);
			wr(WDC_ADDR_COUNT, 8'(c));
			if (c == 1) begin
				repeat (300 * SP) tick();
				wr(WDC_ADDR_CTRL, 8'h03);
				wr(WDC_ADDR_COUNT, WDC_COUNT_LAST);
			end
			wait_por(c);
			do_rst();
			chk("run", {15'h0, dog_run_enable_o}, 16'h0000);
		end
		results();
	end
endmodule
`default_nettype wire
